// File: rtl/fault_status_pkg.sv
// constants for the sticky fault status register
package fault_status_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CTRL1_ADDR = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h2A;
  localparam int RETRY_EN_BIT = 2;
  localparam int RETRY_BIT = 5;
  localparam int OVERCURRENT_BIT = 4;
  localparam int PREWARN_BIT = 3;
  localparam int HEAT_OFF_BIT = 2;
  localparam int LOW_BIT = 1;
  localparam int HIGH_BIT = 0;
  localparam int NUM_FLAGS = 6;
endpackage : fault_status_pkg

// File: rtl/sticky_flag.sv
// one sticky event flag with read clear, set winning
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic clear,
  output logic flag_r
);
  // set over clear so no event is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (event_in) begin
      flag_r <= 1'b1;
    end else if (clear) begin
      flag_r <= 1'b0;
    end
  end
endmodule : sticky_flag

// File: rtl/sticky_fault_status_register.sv
// read-to-clear fault status register with restart enable control
//
// Behaviour
// - bit 5 latches a restart-retry event until the register is next read.
// - bit 4 latches a current limit event until the register is next read.
// - bit 3 latches a thermal pre-warning event until the register is next read.
// - bit 2 latches a thermal shutdown event until the register is next read.
// - bit 1 latches an output undervoltage event until the register is next read.
// - bit 0 latches an output overvoltage event until the register is next read.
// - bits 7 to 6 are reserved, read as zero, and the host ignores them.
// - the status register sits at address 4h and resets to 00h.
// - each flag reports events since the last read, and a read returns then clears them.
// - the restart-retry flag is only set while the restart enable bit of control 1 is one.
`timescale 1ns/1ps
module sticky_fault_status_register (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic retry_event,
  input wire logic overcurrent_event,
  input wire logic heat_prewarn_event,
  input wire logic heat_off_event,
  input wire logic output_low_event,
  input wire logic output_high_event,
  output logic [7:0] reg_rdata_r,
  output logic retry_restart_enable_r
);
  logic [5:0] ev;
  logic [5:0] flags;
  logic status_rd;

  // event vector in bit order, restart gated by enable
  // a retry pulse while disabled is dropped here, never latched later
  assign ev[fault_status_pkg::RETRY_BIT] = retry_event & retry_restart_enable_r;
  assign ev[fault_status_pkg::OVERCURRENT_BIT] = overcurrent_event;
  assign ev[fault_status_pkg::PREWARN_BIT] = heat_prewarn_event;
  assign ev[fault_status_pkg::HEAT_OFF_BIT] = heat_off_event;
  assign ev[fault_status_pkg::LOW_BIT] = output_low_event;
  assign ev[fault_status_pkg::HIGH_BIT] = output_high_event;
  assign status_rd = reg_rd && (reg_addr == fault_status_pkg::STATUS_ADDR);

  // one sticky flag per event
  // set wins inside each flag, so a clash with the read keeps the event
  genvar gi;
  generate
    for (gi = 0; gi < fault_status_pkg::NUM_FLAGS; gi++) begin : g_flag
      sticky_flag u_flag (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(ev[gi]),
        .clear(status_rd),
        .flag_r(flags[gi])
      );
    end
  endgenerate

  // restart enable held from control 1 writes
  // only the enable bit of control 1 is kept, the other bits have no logic here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      retry_restart_enable_r <= fault_status_pkg::CTRL1_RESET[fault_status_pkg::RETRY_EN_BIT];
    end else if (reg_wr && reg_addr == fault_status_pkg::CTRL1_ADDR) begin
      retry_restart_enable_r <= reg_wdata[fault_status_pkg::RETRY_EN_BIT];
    end
  end

  // read data registered, reserved bits zero
  // other addresses read zero and leave the flags alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= fault_status_pkg::STATUS_RESET;
    end else if (status_rd) begin
      reg_rdata_r <= {2'b00, flags};
    end else if (reg_rd) begin
      reg_rdata_r <= 8'h00;
    end
  end

  // assertions
  property p_read_returns;
    @(posedge clk_sys) disable iff (!rst_n)
      status_rd |=> reg_rdata_r == {2'b00, $past(flags)};
  endproperty
  a_read_returns: assert property (p_read_returns) else $error("read data wrong");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n) reg_rdata_r[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_clear_after_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (status_rd && ev == 6'h00) |=> flags == 6'h00;
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) else $error("flags not cleared");

  // a read leaves exactly the events of its own cycle behind
  property p_event_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      status_rd
      |=> flags == $past(ev);
  endproperty
  a_event_wins: assert property (p_event_wins) else $error("event lost on clear");

  property p_retry_gated;
    @(posedge clk_sys) disable iff (!rst_n)
      (!flags[5] && !(retry_event && retry_restart_enable_r)) |=> !flags[5];
  endproperty
  a_retry_gated: assert property (p_retry_gated) else $error("retry flag without enable");

  property p_retry_set;
    @(posedge clk_sys) disable iff (!rst_n)
      retry_event && retry_restart_enable_r |=> flags[5];
  endproperty
  a_retry_set: assert property (p_retry_set) else $error("retry flag missing");

  property p_hold_overcurrent;
    @(posedge clk_sys) disable iff (!rst_n)
      flags[4] && !status_rd |=> flags[4];
  endproperty
  a_hold_overcurrent: assert property (p_hold_overcurrent) else $error("overcurrent flag dropped");

  property p_set_prewarn;
    @(posedge clk_sys) disable iff (!rst_n) heat_prewarn_event |=> flags[3];
  endproperty
  a_set_prewarn: assert property (p_set_prewarn) else $error("prewarn flag missing");

  property p_set_heat_off;
    @(posedge clk_sys) disable iff (!rst_n) heat_off_event ##1 !status_rd |=> flags[2];
  endproperty
  a_set_heat_off: assert property (p_set_heat_off) else $error("heat off flag lost");

  property p_set_low;
    @(posedge clk_sys) disable iff (!rst_n) output_low_event |=> flags[1];
  endproperty
  a_set_low: assert property (p_set_low) else $error("low flag missing");

  property p_set_high;
    @(posedge clk_sys) disable iff (!rst_n) output_high_event |=> flags[0];
  endproperty
  a_set_high: assert property (p_set_high) else $error("high flag missing");

  // each flag holds until a status read
  property p_hold_retry;
    @(posedge clk_sys) disable iff (!rst_n)
      flags[fault_status_pkg::RETRY_BIT] && !status_rd
      |=> flags[fault_status_pkg::RETRY_BIT];
  endproperty
  a_hold_retry: assert property (p_hold_retry) else $error("retry flag dropped");

  property p_hold_prewarn;
    @(posedge clk_sys) disable iff (!rst_n)
      flags[fault_status_pkg::PREWARN_BIT] && !status_rd
      |=> flags[fault_status_pkg::PREWARN_BIT];
  endproperty
  a_hold_prewarn: assert property (p_hold_prewarn) else $error("prewarn flag dropped");

  property p_hold_heat_off;
    @(posedge clk_sys) disable iff (!rst_n)
      flags[fault_status_pkg::HEAT_OFF_BIT] && !status_rd
      |=> flags[fault_status_pkg::HEAT_OFF_BIT];
  endproperty
  a_hold_heat_off: assert property (p_hold_heat_off) else $error("heat off flag dropped");

  property p_hold_low;
    @(posedge clk_sys) disable iff (!rst_n)
      flags[fault_status_pkg::LOW_BIT] && !status_rd
      |=> flags[fault_status_pkg::LOW_BIT];
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("low flag dropped");

  property p_hold_high;
    @(posedge clk_sys) disable iff (!rst_n)
      flags[fault_status_pkg::HIGH_BIT] && !status_rd
      |=> flags[fault_status_pkg::HIGH_BIT];
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("high flag dropped");

  // without a status read flags only gather events
  property p_accumulate;
    @(posedge clk_sys) disable iff (!rst_n)
      !status_rd |=> flags == ($past(flags) | $past(ev));
  endproperty
  a_accumulate: assert property (p_accumulate) else $error("flags changed without read");

  // a control 1 write loads the restart enable
  property p_enable_write;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_wr && reg_addr == fault_status_pkg::CTRL1_ADDR
      |=> retry_restart_enable_r == $past(reg_wdata[fault_status_pkg::RETRY_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not loaded");

  // any other cycle keeps the restart enable
  property p_enable_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !(reg_wr && reg_addr == fault_status_pkg::CTRL1_ADDR)
      |=> $stable(retry_restart_enable_r);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed unasked");

  // reads of other addresses return zero
  property p_other_read_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr != fault_status_pkg::STATUS_ADDR
      |=> reg_rdata_r == 8'h00;
  endproperty
  a_other_read_zero: assert property (p_other_read_zero) else $error("other read not zero");

  // read data stands until the next read strobe
  property p_rdata_stands;
    @(posedge clk_sys) disable iff (!rst_n)
      !reg_rd
      |=> $stable(reg_rdata_r);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");

  c_read_set: cover property (@(posedge clk_sys) disable iff (!rst_n)
    status_rd && flags != 6'h00);
  c_collide: cover property (@(posedge clk_sys) disable iff (!rst_n) status_rd && ev != 6'h00);
  c_enable_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == fault_status_pkg::CTRL1_ADDR);
  c_retry_blocked: cover property (@(posedge clk_sys) disable iff (!rst_n)
    retry_event && !retry_restart_enable_r);
  c_other_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr != fault_status_pkg::STATUS_ADDR);
endmodule : sticky_fault_status_register

// File: dv/fault_host_model.sv
// host model that polls the fault status register
`timescale 1ns/1ps
module fault_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata_r,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic [5:0] flags_seen
);
  // host looks at defined flags only
  assign flags_seen = reg_rdata_r[5:0];
  // bus idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  end
  // one strobe cycle, entered at a falling edge
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a; // address driven inverted, stale value gone
    @(negedge clk_sys);
  endtask : access
endmodule : fault_host_model

// File: dv/sticky_fault_status_register_tb_top.sv
// self-checking bench for the sticky fault status register
`timescale 1ns/1ps
module sticky_fault_status_register_tb_top;
  logic clk_sys;
  logic rst_n;
  logic [5:0] ev;
  logic [5:0] seen;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic reg_rd, reg_wr, en;
  int num_errors = 0;
  int n_checks = 0;
  logic [13:0] rows [7] = '{14'h2020, 14'h1010, 14'h0808, 14'h0404, 14'h0202, 14'h0101, 14'h3F3F};
  sticky_fault_status_register sticky_fault_status_register_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .retry_event(ev[5]),
    .overcurrent_event(ev[4]), .heat_prewarn_event(ev[3]), .heat_off_event(ev[2]),
    .output_low_event(ev[1]), .output_high_event(ev[0]), .reg_rdata_r(rdata),
    .retry_restart_enable_r(en));
  fault_host_model fault_host_model_inst (
    .clk_sys(clk_sys), .reg_rdata_r(rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .flags_seen(seen));
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic rd4;
    fault_host_model_inst.access(fault_status_pkg::STATUS_ADDR, 8'h00, 1'b0);
  endtask : rd4
  task automatic pulse(input logic [5:0] v);
    ev = v;
    @(negedge clk_sys);
    ev = 6'h00;
    repeat (3) @(negedge clk_sys);
  endtask : pulse
  // watchdog
  initial begin
    repeat (400) @(posedge clk_sys);
    num_errors++;
    test_done;
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    ev = 6'h00;
    repeat (8) @(negedge clk_sys);
    chk(rdata, 8'h00);
    chk({7'h00, en}, 8'h00);
    rst_n = 1'b1;
    @(negedge clk_sys);
    pulse(6'h20);
    rd4;
    chk(rdata, 8'h00);
    fault_host_model_inst.access(fault_status_pkg::CTRL1_ADDR, 8'h04, 1'b1);
    chk({7'h00, en}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      pulse(rows[i][13:8]);
      rd4;
      chk(rdata, rows[i][7:0]);
      chk({2'b00, seen}, rows[i][7:0]);
      rd4;
      chk(rdata, 8'h00);
    end
    // event landing on the clearing read
    pulse(6'h11);
    fork
      rd4;
      pulse(6'h02);
    join
    chk(rdata, 8'h11);
    rd4;
    chk(rdata, 8'h02);
    // status write ignored, other address reads zero without clearing
    pulse(6'h08);
    fault_host_model_inst.access(fault_status_pkg::STATUS_ADDR, 8'h00, 1'b1);
    fault_host_model_inst.access(8'h03, 8'h00, 1'b0);
    chk(rdata, 8'h00);
    rd4;
    chk(rdata, 8'h08);
    // reset in mid-run
    pulse(6'h04);
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk({7'h00, en}, 8'h00);
    rd4;
    chk(rdata, 8'h00);
    test_done;
  end
endmodule : sticky_fault_status_register_tb_top
